/* hw/sic_control_port.sv */
/*
 * Synthesizer control port: an I2C slave for write and status read transfers,
 * holding the divide count, control settings and band outputs, plus the
 * 3-wire ratio carry-over hook and the bus select muxing of the shared pins.
 * Assumes SCL and SDA are already synchronous to core_clk_i and the power-up
 * event and analogue level code come from outside as synchronous levels.
 */
`timescale 1ns/1ps
`default_nettype none

module sic_control_port (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [1:0] addr_pin_level_i,
    input wire logic bus_select_pin_i,
    input wire logic supply_event_i,
    input wire logic supply_ok_i,
    input wire logic lock_flag_i,
    input wire logic [2:0] level_code_i,
    input wire logic wire3_exit_i,
    input wire logic wire3_len19_i,
    output logic [14:0] divide_count_o,
    output sic_pkg::sic_ctl_s ctl_o,
    output sic_pkg::sic_test_s test_o,
    output logic [3:0] band_output_bits_o,
    output logic vhf_mode_o,
    output logic lock_pin_n_o,
    output logic i2c_mode_o
);
    import sic_pkg::*;

    // How a transfer moves through this port.
    // The serial clock and data levels arrive already synchronous to the core clock.
    // Each level is kept one cycle in a flop, so an edge is seen in the cycle the new level arrives.
    // A start is a fall of the data line while the clock line stays high.
    // A stop is a rise of the data line while the clock line stays high.
    // A start in any phase restarts the byte machinery from the address byte.
    // A stop in any phase returns the port to idle and releases the data line.
    // Bits are taken at the rising edge of the serial clock, most significant first.
    // The eighth rising edge of a byte completes it and decides what follows.
    // An address byte that matches moves the port into the acknowledge phase.
    // An address byte that does not match moves it into the skip phase.
    // In the skip phase the port ignores every bit until the next start or stop.
    // The acknowledge drive starts at the serial clock fall after the eighth bit.
    // It is held through the ninth clock and dropped at the fall that ends it.
    // The data line is only ever pulled low; a released line is left to the pull-up.
    // That is why the data output value is a constant and only its enable moves.
    // A read address leads from the acknowledge phase into the send phase.
    // The first status bit is put out at the same fall that ends the acknowledge.
    // The other seven status bits follow, one at each later fall of the clock.
    // After the eighth status bit the port stops driving and waits in skip.
    // The answer of the master to the status byte is not looked at.
    // Only one status byte is sent per read; further clocks see a released line.
    // A write address leads from the acknowledge phase back into receive.
    // Every data byte of a write is acknowledged, whatever its contents.
    // The top bit of a data byte tells a first frequency byte from a control byte.
    // The byte after a first frequency byte is always its second half.
    // That second half may carry any top bit, so it is not classified.
    // The byte straight after a control byte is band data, whatever its top bit.
    // A first frequency byte is only parked; the active count keeps its value.
    // The count moves only when the second frequency byte completes.
    // So the counter after the prescaler never sees a half-written ratio.
    // A start or stop between the two halves throws the parked half away.
    // Control and band bytes take effect at the end of their own byte.
    // Values already taken stay in force when a transfer is cut short.
    // There is no byte limit; the master may sweep frequency in one transfer.
    // The ratio bits can also move from the 3-wire side at a test mode exit.
    // That hook only acts while the 3-wire interface is selected.
    // It rewrites the first ratio bit from the word length and keeps the second.
    // The power-up flag is raised by a supply event and by reset.
    // It is cleared one cycle after a status byte with it set has gone out.
    // The clear also needs an adequate supply at that moment.
    // A supply event in the same cycle as the clear wins, so the flag stays set.
    // The lock flag and level code are put into the status byte as they stand.
    // They are taken at the start of the status byte, so the byte is coherent.
    // The analogue-side decodes of the test code lag the control byte by a cycle.
    // The band mode output also lags the band bits by one cycle.
    // Both lags are harmless, the analogue circuits settle far slower.
    // While the 3-wire interface is selected the I2C logic stays idle.
    // The lock output pin is only active in that mode and is active low.
    // A limitation: the 3-wire shift logic itself lives outside this block.
    // Another limitation: the pins are not filtered, a glitch is taken as an edge.
    // The master must hold each level for more than two core clocks.
    // Clock stretching is not used; the port never holds the clock line low.

    // Transfer phases; one-hot so each phase is a single flop.
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK = 5'h04,
        ST_SEND = 5'h08,
        ST_SKIP = 5'h10
    } sic_state_e;

    sic_state_e state_q, state_d;
    logic scl_q, sda_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic is_addr_q;
    logic read_q;
    logic after_ctl_q;
    logic [6:0] freq_hi_q;
    logic freq_pend_q;
    logic [14:0] count_q;
    sic_ctl_s ctl_q;
    logic [3:0] band_q;
    logic por_q;
    logic por_sent_q;
    logic [7:0] stat_q;
    logic sda_oe_q;
    sic_test_s test_q;
    logic vhf_q, lock_n_q, i2c_q;

    // Decodes the control byte into its setting fields.
    function automatic sic_ctl_s ctl_of(input logic [7:0] b);
        sic_ctl_s c;
        c.pump_current_select = b[SIC_CTL_PUMP_BIT];
        c.test_select = b[SIC_CTL_TEST_HI:SIC_CTL_TEST_LO];
        c.ratio_select = {b[SIC_CTL_RSA_BIT], b[SIC_CTL_RSB_BIT]};
        c.tune_amp_disable = b[SIC_CTL_AMP_BIT];
        return c;
    endfunction : ctl_of

    // Bus events seen on the sampled pins.
    wire scl_rise = scl_i & ~scl_q;
    wire scl_fall = ~scl_i & scl_q;
    wire start_cond = scl_i & scl_q & sda_q & ~sda_i;
    wire stop_cond = scl_i & scl_q & ~sda_q & sda_i;
    wire i2c_sel = ~bus_select_pin_i;
    wire [7:0] rx_byte = {shift_q[6:0], sda_i};
    wire byte_done = scl_rise & (bit_cnt_q == 3'h7);
    wire [6:0] my_addr = {SIC_ADDR_FIXED, addr_pin_level_i};
    wire addr_match = (rx_byte[7:1] == my_addr);
    wire data_byte = byte_done & ~is_addr_q & (state_q == ST_RECV);
    wire is_freq_byte = ~rx_byte[7] & ~after_ctl_q;
    wire is_ctl_byte = rx_byte[7] & ~after_ctl_q;
    wire is_band_byte = after_ctl_q;
    wire [7:0] stat_byte = {por_q, lock_flag_i, SIC_STAT_ONES, level_code_i};
    wire [2:0] tsel = ctl_q.test_select;

    // Phase sequencing; start wins over every phase, though stop and 3-wire select come first, so a repeated start restarts cleanly.
    always_comb begin
        state_d = state_q;
        if (!i2c_sel || stop_cond) begin
            state_d = ST_IDLE;
        end else if (start_cond) begin
            state_d = ST_RECV;
        end else begin
            case (state_q)
                ST_RECV: begin
                    if (byte_done) begin
                        state_d = (is_addr_q && !addr_match) ? ST_SKIP : ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall && sda_oe_q) begin
                        state_d = read_q ? ST_SEND : ST_RECV;
                    end
                end
                ST_SEND: begin
                    if (byte_done) begin
                        state_d = ST_SKIP;
                    end
                end
                ST_IDLE: state_d = ST_IDLE;
                ST_SKIP: state_d = ST_SKIP;
                default: state_d = ST_IDLE;
            endcase
        end
    end

    // Pin sampling and phase register.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state_q <= state_d;
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Bit counter and receive shifter, restarted at each start and after each ack.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || start_cond || state_q == ST_ACK) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
        end else if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q <= rx_byte;
        end
    end

    // Transfer context: address phase, direction and band-follows-control.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || start_cond) begin
            is_addr_q <= 1'b1;
            read_q <= 1'b0;
            after_ctl_q <= 1'b0;
        end else if (byte_done && state_q == ST_RECV) begin
            is_addr_q <= 1'b0;
            if (is_addr_q) begin
                read_q <= rx_byte[0];
            end else begin
                // A second frequency byte may carry a top bit of one; it must not open
                // the band slot, or the next control byte would be taken as band data.
                after_ctl_q <= is_ctl_byte && !freq_pend_q;
            end
        end
    end

    // Write data latching; a frequency byte pair must be complete before use.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            freq_hi_q <= 7'h00;
            freq_pend_q <= 1'b0;
            count_q <= SIC_COUNT_RST;
            ctl_q <= '{1'b0, SIC_TEST_RST, SIC_RATIO_RST, 1'b0};
            band_q <= SIC_BAND_RST;
        end else if (start_cond || stop_cond) begin
            freq_pend_q <= 1'b0;
        end else if (data_byte && !read_q) begin
            if (freq_pend_q) begin
                count_q <= {freq_hi_q, rx_byte};
                freq_pend_q <= 1'b0;
            end else if (is_freq_byte) begin
                freq_hi_q <= rx_byte[6:0];
                freq_pend_q <= 1'b1;
            end else if (is_ctl_byte) begin
                ctl_q <= ctl_of(rx_byte);
            end else begin
                band_q <= rx_byte[3:0];
            end
        end else if (wire3_exit_i && !i2c_sel) begin
            ctl_q.ratio_select[1] <= ~wire3_len19_i;
        end
    end

    // Power-up flag: a supply event wins over the clear from a finished read.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            por_q <= 1'b1;
            por_sent_q <= 1'b0;
        end else begin
            if (supply_event_i) begin
                por_q <= 1'b1;
            end else if (por_sent_q && supply_ok_i) begin
                por_q <= 1'b0;
            end
            por_sent_q <= (state_q == ST_SEND) && byte_done && por_q && !supply_event_i;
        end
    end

    // Data line drive: ack low, then status bits MSB first; otherwise released.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || !i2c_sel || start_cond || stop_cond) begin
            sda_oe_q <= 1'b0;
            stat_q <= 8'h00;
        end else if (scl_fall) begin
            if (state_q == ST_ACK && !sda_oe_q) begin
                sda_oe_q <= 1'b1;
            end else if (state_q == ST_ACK && read_q) begin
                stat_q <= {stat_byte[6:0], 1'b0};
                sda_oe_q <= ~stat_byte[7];
            end else if (state_q == ST_SEND && bit_cnt_q != 3'h0) begin
                stat_q <= {stat_q[6:0], 1'b0};
                sda_oe_q <= ~stat_q[7];
            end else begin
                sda_oe_q <= 1'b0;
            end
        end
    end

    // Analogue-side decodes, registered so the outputs come straight from flops.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            test_q <= '0;
            vhf_q <= 1'b0;
            lock_n_q <= 1'b1;
            i2c_q <= 1'b0;
        end else begin
            test_q.pump_off <= (tsel[2:1] == 2'h1);
            test_q.pump_sink_only <= (tsel == SIC_TEST_SINK);
            test_q.pump_source_only <= (tsel == SIC_TEST_SOURCE);
            test_q.route_ref <= (tsel == SIC_TEST_REFOUT);
            test_q.route_half <= (tsel == SIC_TEST_HALFOUT);
            test_q.cmp_test <= (tsel == SIC_TEST_CMPTEST);
            vhf_q <= band_q[0] | band_q[1];
            lock_n_q <= i2c_sel | ~lock_flag_i;
            i2c_q <= i2c_sel;
        end
    end

    // The ack and status drive only ever pull low; the output value is tied by design.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    assign sda_oe_o = sda_oe_q;
    assign divide_count_o = count_q;
    assign ctl_o = ctl_q;
    assign test_o = test_q;
    assign band_output_bits_o = band_q;
    assign vhf_mode_o = vhf_q;
    assign lock_pin_n_o = lock_n_q;
    assign i2c_mode_o = i2c_q;

endmodule : sic_control_port

`default_nettype wire

/* hw/sic_pkg.sv */
/*
 * Package for the synthesizer I2C control port: status and control field layout,
 * address bits, test codes and the structs that carry the latched settings.
 * Assumes a single clock domain on the core clock; bus pins are sampled synchronously.
 */
package sic_pkg;

    // Fixed upper five bits of the slave address, MSB first.
    localparam logic [4:0] SIC_ADDR_FIXED = 5'h18;

    // Control byte field positions, counted from the LSB of the received byte.
    localparam int SIC_CTL_PUMP_BIT = 6;
    localparam int SIC_CTL_TEST_HI = 5;
    localparam int SIC_CTL_TEST_LO = 3;
    localparam int SIC_CTL_RSA_BIT = 2;
    localparam int SIC_CTL_RSB_BIT = 1;
    localparam int SIC_CTL_AMP_BIT = 0;

    // Reset values of the latched settings.
    localparam logic [14:0] SIC_COUNT_RST = 15'h0000;
    localparam logic [2:0] SIC_TEST_RST = 3'h1;
    localparam logic [1:0] SIC_RATIO_RST = 2'h3;
    localparam logic [3:0] SIC_BAND_RST = 4'h0;

    // Test mode codes, written as the hi, mid, lo select bits.
    localparam logic [2:0] SIC_TEST_CMPTEST = 3'h0;
    localparam logic [2:0] SIC_TEST_NORMAL = 3'h1;
    localparam logic [2:0] SIC_TEST_REFOUT = 3'h4;
    localparam logic [2:0] SIC_TEST_HALFOUT = 3'h5;
    localparam logic [2:0] SIC_TEST_SINK = 3'h6;
    localparam logic [2:0] SIC_TEST_SOURCE = 3'h7;

    // Three fixed ones between the lock flag and the level code in the status byte.
    localparam logic [2:0] SIC_STAT_ONES = 3'h7;

    // Settings taken from the control byte.
    typedef struct packed {
        logic pump_current_select;
        logic [2:0] test_select;
        logic [1:0] ratio_select;
        logic tune_amp_disable;
    } sic_ctl_s;

    // Decoded drive for the analogue side.
    typedef struct packed {
        logic pump_off;
        logic pump_sink_only;
        logic pump_source_only;
        logic route_ref;
        logic route_half;
        logic cmp_test;
    } sic_test_s;

endpackage : sic_pkg

/* testbench/sic_control_port_checker.sv */
/* Port-level assertions for the synthesizer control port.
   Assumes it is bound to sic_control_port, running on its single core clock. */
`timescale 1ns/1ps
`default_nettype none
module sic_control_port_checker (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic bus_select_pin_i,
    input wire logic lock_flag_i,
    input wire logic wire3_exit_i,
    input wire logic wire3_len19_i,
    input wire logic [14:0] divide_count_o,
    input wire sic_pkg::sic_ctl_s ctl_o,
    input wire sic_pkg::sic_test_s test_o,
    input wire logic [3:0] band_output_bits_o,
    input wire logic vhf_mode_o,
    input wire logic lock_pin_n_o,
    input wire logic i2c_mode_o
);
    import sic_pkg::*;
    // One clock domain, so the clock and the reset are declared once.
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // The data line may only move while the clock line is low, or a start or stop is faked.
    a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("sda drive moved while scl was high");
    a_count_at_bit: assert property ($changed(divide_count_o) |-> scl_i && !sda_oe_o)
        else $error("divide count moved outside a data bit");
    a_ctl_at_bit: assert property ($changed(ctl_o) || $changed(band_output_bits_o) |-> scl_i)
        else $error("control or band moved outside a data bit");
    a_test_decode: assert property (test_o == {$past(ctl_o.test_select[2:1]) == 2'h1,
        $past(ctl_o.test_select) == SIC_TEST_SINK, $past(ctl_o.test_select) == SIC_TEST_SOURCE,
        $past(ctl_o.test_select) == SIC_TEST_REFOUT, $past(ctl_o.test_select) == SIC_TEST_HALFOUT,
        $past(ctl_o.test_select) == SIC_TEST_CMPTEST}) else $error("test decode wrong");
    a_vhf_band: assert property (vhf_mode_o == (|$past(band_output_bits_o[1:0])))
        else $error("vhf mode does not follow band bits");
    a_mode_select: assert property (bus_select_pin_i ##1 bus_select_pin_i |-> !i2c_mode_o)
        else $error("i2c mode kept while 3-wire selected");
    a_quiet_3wire: assert property (bus_select_pin_i ##1 bus_select_pin_i |-> !sda_oe_o)
        else $error("sda driven while 3-wire selected");
    a_lock_pin: assert property ((!i2c_mode_o && $stable(lock_flag_i)) [*2] |->
        lock_pin_n_o == !lock_flag_i) else $error("lock pin wrong in 3-wire mode");
    a_ratio_exit: assert property (wire3_exit_i && bus_select_pin_i |->
        ##[1:2] ctl_o.ratio_select[1] == !wire3_len19_i) else $error("ratio bit after exit");
    cover property ($rose(sda_oe_o));
    cover property ($changed(divide_count_o));
    cover property (wire3_exit_i && bus_select_pin_i);
endmodule : sic_control_port_checker
bind sic_control_port sic_control_port_checker chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .scl_i(scl_i), .sda_oe_o(sda_oe_o), .bus_select_pin_i(bus_select_pin_i),
    .lock_flag_i(lock_flag_i), .wire3_exit_i(wire3_exit_i), .wire3_len19_i(wire3_len19_i),
    .divide_count_o(divide_count_o), .ctl_o(ctl_o), .test_o(test_o),
    .band_output_bits_o(band_output_bits_o), .vhf_mode_o(vhf_mode_o),
    .lock_pin_n_o(lock_pin_n_o), .i2c_mode_o(i2c_mode_o));
`default_nettype wire

/* testbench/sic_control_port_tb.sv */
/* Self-checking bench for the synthesizer control port.
   Assumes sic_i2c_master drives the bus and the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module sic_control_port_tb;
    import sic_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic scl, m_sda, sda_oe, sda_o, sda_w, a, vhf, lock_n, i2c_mode;
    logic bus_sel = 1'b0, sup_ev = 1'b0, sup_ok = 1'b1, lock = 1'b0, w3_exit = 1'b0, w3_len = 1'b0;
    logic [1:0] addr_pin = 2'h0;
    logic [2:0] lvl = 3'h0;
    logic [14:0] cnt, c;
    logic [7:0] b;
    sic_ctl_s ctl;
    sic_test_s tst;
    logic [3:0] band;
    logic [25:0] exp_q[$];
    logic [25:0] last_seen, last_noted, m;
    int num_errors = 0, checks_done = 0, seed = 35399;
    // Open-drain data line with a pull-up.
    assign sda_w = m_sda & ~(sda_oe & ~sda_o);
    always #2.5 core_clk = ~core_clk;
    sic_control_port uut (.core_clk_i(core_clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_pin_level_i(addr_pin), .bus_select_pin_i(bus_sel),
        .supply_event_i(sup_ev), .supply_ok_i(sup_ok), .lock_flag_i(lock), .level_code_i(lvl),
        .wire3_exit_i(w3_exit), .wire3_len19_i(w3_len), .divide_count_o(cnt), .ctl_o(ctl),
        .test_o(tst), .band_output_bits_o(band), .vhf_mode_o(vhf), .lock_pin_n_o(lock_n),
        .i2c_mode_o(i2c_mode));
    sic_i2c_master mst (.clk_i(core_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
    task automatic check(input logic [25:0] seen, input logic [25:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Notes a new expected settings word; an unchanged word leaves nothing to see.
    task automatic note();
        if (m !== last_noted) exp_q.push_back(m);
        last_noted = m;
    endtask : note
    task automatic wb(input logic [7:0] v, input logic exp_ack);
        mst.send_byte(v, a);
        check(26'(a), 26'(exp_ack));
    endtask : wb
    task automatic rd_stat(input logic por);
        mst.start_c();
        wb({SIC_ADDR_FIXED, addr_pin, 1'b1}, 1'b1);
        mst.recv_byte(b);
        mst.stop_c();
        check(26'(b), 26'({por, lock, SIC_STAT_ONES, lvl}));
    endtask : rd_stat
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // Any change of the held settings must match the oldest note, else it is unexpected.
    always @(posedge core_clk) begin
        if (nrst && {cnt, ctl, band} !== last_seen)
            check({cnt, ctl, band}, exp_q.size() > 0 ? exp_q.pop_front() : last_seen);
        last_seen <= {cnt, ctl, band};
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        give_verdict();
    end
    initial begin
        m = {SIC_COUNT_RST, 1'b0, SIC_TEST_RST, SIC_RATIO_RST, 1'b0, SIC_BAND_RST};
        last_noted = m;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        check({cnt, ctl, band}, m);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            addr_pin <= i[1:0];
            mst.start_c();
            wb({SIC_ADDR_FIXED, i[1:0] ^ 2'h1, 1'b0}, 1'b0);
            wb(8'h12, 1'b0);
            mst.start_c();
            wb({SIC_ADDR_FIXED, i[1:0], 1'b0}, 1'b1);
            for (int k = 0; k < 4; k++) begin
                b = 8'($random(seed));
                b[7] = 1'b1;
                b[5:3] = 3'(2 * i + k % 2);
                m[10:4] = b[6:0];
                note();
                wb(b, 1'b1);
                b = 8'($random(seed));
                m[3:0] = b[3:0];
                note();
                wb(b, 1'b1);
                c = 15'($random(seed));
                wb({1'b0, c[14:8]}, 1'b1);
                m[25:11] = c;
                note();
                wb(c[7:0], 1'b1);
            end
            mst.stop_c();
        end
        mst.start_c();
        wb({SIC_ADDR_FIXED, addr_pin, 1'b0}, 1'b1);
        wb({1'b0, ~m[25:19]}, 1'b1);
        mst.stop_c();
        for (int k = 0; k < 9; k++) begin
            @(posedge core_clk);
            lvl <= 3'(k % 5);
            lock <= k[0];
            sup_ev <= (k == 5);
            sup_ok <= (k < 5 || k > 6);
            repeat (8) @(posedge core_clk);
            sup_ev <= 1'b0;
            rd_stat(k == 0 || (k > 4 && k < 8));
        end
        @(posedge core_clk);
        bus_sel <= 1'b1;
        mst.start_c();
        wb({SIC_ADDR_FIXED, addr_pin, 1'b0}, 1'b0);
        mst.stop_c();
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            w3_len <= k[0];
            lock <= ~lock;
            m[6] = ~k[0];
            note();
            @(posedge core_clk);
            w3_exit <= 1'b1;
            @(posedge core_clk);
            w3_exit <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
        bus_sel <= 1'b0;
        repeat (10) @(posedge core_clk);
        check(26'(exp_q.size()), 26'h0);
        give_verdict();
    end
endmodule : sic_control_port_tb
`default_nettype wire

/* testbench/sic_i2c_master.sv */
/* Behavioural I2C bus master that drives the control port in the bench.
   Assumes an external pull-up, so sda_i is the resolved wire level. */
`timescale 1ns/1ps
`default_nettype none
module sic_i2c_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // Idle bus: both lines released high.
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // A quarter bit of four clocks keeps every phase well clear of the sampler.
    task automatic qtr();
        repeat (4) @(posedge clk_i);
    endtask : qtr
    // Start from idle, or a repeated start from a low clock line.
    task automatic start_c();
        sda_o <= 1'b1;
        qtr();
        scl_o <= 1'b1;
        qtr();
        sda_o <= 1'b0;
        qtr();
        scl_o <= 1'b0;
        qtr();
    endtask : start_c
    // A stop ends a run of data bytes, as does a repeated start.
    task automatic stop_c();
        sda_o <= 1'b0;
        qtr();
        scl_o <= 1'b1;
        qtr();
        sda_o <= 1'b1;
        qtr();
    endtask : stop_c
    // Data changes only while the clock is low; the wire is sampled mid-high.
    task automatic bit_x(input logic b, output logic r);
        sda_o <= b;
        qtr();
        scl_o <= 1'b1;
        qtr();
        r = sda_i;
        qtr();
        scl_o <= 1'b0;
        qtr();
    endtask : bit_x
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask : send_byte
    // Reads one byte and answers with a not-acknowledge.
    task automatic recv_byte(output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
        bit_x(1'b1, r);
    endtask : recv_byte
endmodule : sic_i2c_master
`default_nettype wire
